/* File: rtl/dsf_status_bank.v */
// device status and fault-class summary register bank
//
// Function
// - status bit 7 reads 1 while any fault class bit is set; writes ignored
// - status bit 6 follows the differential fault input and feeds the fault output while high-side enable is 1
// - live and latched chain alarm bits read 0 when high-side enable is 0
// - status bit 5 latches any chain fault until written 1; never drives fault output
// - status bit 4 sticky on link clear, write 1 clears, no fault output
// - status bit 3 sticky on link reset, write 1 clears, no fault output
// - status bit 1 read-only, set when conversion results become available
// - reading any conversion result clears the fresh-sample bit
// - automatic die-temperature and init sampling never set the fresh-sample bit
// - one fresh-sample bit only, no per-channel tracking
// - status bit 0 reads 1 while initialization runs, 0 once done
// - writing 1 to bit 0 stops waiting for the pump rail; 0 does nothing
// - summary bits 15..6 each OR one fault class
// - writing 1 to a summary bit clears that whole class; 0 does nothing
// - summary bits follow class bits, latched or self-clearing per config
// - summary bits 5..0 read as zero
// - with self-clear set, class bits drop once their condition disappears
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defs.vh"

module dsf_status_bank #(
    parameter NUM_CLASSES = `DSF_NUM_CLASSES
) (
    input wire mclk,
    input wire rst_n,
    input wire [`DSF_ADDR_W-1:0] reg_addr,
    input wire [`DSF_DATA_W-1:0] reg_wdata,
    input wire reg_wr_stb,
    input wire reg_rd_stb,
    input wire chain_fault_in,
    input wire link_clear_evt,
    input wire link_reset_evt,
    input wire sample_done,
    input wire sample_is_auto,
    input wire result_read,
    input wire init_done,
    input wire [NUM_CLASSES-1:0] class_cond,
    output reg [`DSF_DATA_W-1:0] reg_rdata_r,
    output reg fault_out_r,
    output reg irq_r,
    output reg init_continue_r,
    output reg [NUM_CLASSES-1:0] class_clear_r
);

    // ****************************************
    // state
    // ****************************************
    reg chain_live_r;
    reg chain_seen_r;
    reg link_clear_seen_r;
    reg link_reset_seen_r;
    reg new_sample_r;
    reg init_in_progress_r;
    reg [1:0] config_r;
    reg [NUM_CLASSES-1:0] class_r;
    reg [`DSF_IRQ_W-1:0] irq_stat_r;
    reg [`DSF_IRQ_W-1:0] irq_mask_r;
    reg [`DSF_DATA_W-1:0] rd_nxt;
    wire high_en;
    wire self_clear_alarms;
    wire any_class;
    wire [`DSF_IRQ_W-1:0] irq_evt;
    wire [NUM_CLASSES-1:0] sum_w1c;
    wire [NUM_CLASSES-1:0] class_nxt;

    // decode of a write to one register
    function wr_hit;
        input [`DSF_ADDR_W-1:0] a;
        input [`DSF_ADDR_W-1:0] ofs;
        input stb;
        begin
            wr_hit = stb && (a == ofs);
        end
    endfunction

    wire wr_status = wr_hit(reg_addr, `DSF_OFS_DEVICE_STATUS, reg_wr_stb);
    wire wr_summary = wr_hit(reg_addr, `DSF_OFS_FAULT_SUMMARY, reg_wr_stb);
    wire wr_irq_stat = wr_hit(reg_addr, `DSF_OFS_IRQ_STATUS, reg_wr_stb);
    wire wr_irq_mask = wr_hit(reg_addr, `DSF_OFS_IRQ_MASK, reg_wr_stb);
    wire wr_config = wr_hit(reg_addr, `DSF_OFS_CONFIG, reg_wr_stb);

    assign high_en = config_r[`DSF_CFG_HIGH_EN];
    assign self_clear_alarms = config_r[`DSF_CFG_SELF_CLEAR];
    assign any_class = |class_r;
    assign sum_w1c = wr_summary ? reg_wdata[`DSF_SUM_LSB +: NUM_CLASSES] : {NUM_CLASSES{1'b0}};

    // ****************************************
    // fault classes
    // ****************************************
    // next value of one latch per class; set beats a same-cycle clear
    genvar g;
    generate
        for (g = 0; g < NUM_CLASSES; g = g + 1)
        begin : g_class
            assign class_nxt[g] = class_cond[g] ? 1'b1 :
                                  ((sum_w1c[g] || self_clear_alarms) ? 1'b0 : class_r[g]);
        end
    endgenerate

    // all class latches in one process, so each bit has a single driver
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            class_r <= {NUM_CLASSES{1'b0}};
        else
            class_r <= class_nxt;
    end

    // clear pulse toward the underlying fault registers
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            class_clear_r <= {NUM_CLASSES{1'b0}};
        else
            class_clear_r <= sum_w1c;
    end

    // ****************************************
    // status flags
    // ****************************************
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chain_live_r <= 1'b0;
            chain_seen_r <= 1'b0;
            link_clear_seen_r <= 1'b0;
            link_reset_seen_r <= 1'b0;
            new_sample_r <= 1'b0;
            init_in_progress_r <= 1'b1;
            init_continue_r <= 1'b0;
        end
        else
        begin
            chain_live_r <= chain_fault_in;
            if (chain_fault_in)
                chain_seen_r <= 1'b1;
            else if (wr_status && reg_wdata[`DSF_ST_CHAIN_SEEN])
                chain_seen_r <= 1'b0;
            if (link_clear_evt)
                link_clear_seen_r <= 1'b1;
            else if (wr_status && reg_wdata[`DSF_ST_LINK_CLEAR])
                link_clear_seen_r <= 1'b0;
            if (link_reset_evt)
                link_reset_seen_r <= 1'b1;
            else if (wr_status && reg_wdata[`DSF_ST_LINK_RESET])
                link_reset_seen_r <= 1'b0;
            // single flag, automatic sampling excluded, set beats read-clear
            if (sample_done && !sample_is_auto)
                new_sample_r <= 1'b1;
            else if (result_read)
                new_sample_r <= 1'b0;
            if (init_done)
                init_in_progress_r <= 1'b0;
            init_continue_r <= wr_status && reg_wdata[`DSF_ST_INIT] && init_in_progress_r;
        end
    end

    // ****************************************
    // configuration and interrupts
    // ****************************************
    assign irq_evt = {sample_done && !sample_is_auto, link_reset_evt, link_clear_evt,
                      chain_fault_in && high_en, |class_cond};

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_r <= `DSF_CFG_RESET;
            irq_mask_r <= `DSF_IRQ_MASK_RESET;
            irq_stat_r <= {`DSF_IRQ_W{1'b0}};
            irq_r <= 1'b0;
            fault_out_r <= 1'b0;
        end
        else
        begin
            if (wr_config)
                config_r <= reg_wdata[1:0];
            if (wr_irq_mask)
                irq_mask_r <= reg_wdata[`DSF_IRQ_W-1:0];
            // events win over write-one-to-clear
            irq_stat_r <= irq_evt | (irq_stat_r & ~(wr_irq_stat ? reg_wdata[`DSF_IRQ_W-1:0] : {`DSF_IRQ_W{1'b0}}));
            irq_r <= |(irq_stat_r & irq_mask_r);
            // latched chain bit and sticky link bits stay out of the fault output
            fault_out_r <= any_class || (chain_live_r && high_en);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always @*
    begin
        rd_nxt = {`DSF_DATA_W{1'b0}};
        case (reg_addr)
            `DSF_OFS_DEVICE_STATUS:
            begin
                rd_nxt[`DSF_ST_FAULT] = any_class;
                rd_nxt[`DSF_ST_CHAIN_LIVE] = chain_live_r && high_en;
                rd_nxt[`DSF_ST_CHAIN_SEEN] = chain_seen_r && high_en;
                rd_nxt[`DSF_ST_LINK_CLEAR] = link_clear_seen_r;
                rd_nxt[`DSF_ST_LINK_RESET] = link_reset_seen_r;
                rd_nxt[`DSF_ST_NEW_SAMPLE] = new_sample_r;
                rd_nxt[`DSF_ST_INIT] = init_in_progress_r;
            end
            `DSF_OFS_FAULT_SUMMARY:
                rd_nxt[`DSF_SUM_LSB +: NUM_CLASSES] = class_r;
            `DSF_OFS_IRQ_STATUS:
                rd_nxt[`DSF_IRQ_W-1:0] = irq_stat_r;
            `DSF_OFS_IRQ_MASK:
                rd_nxt[`DSF_IRQ_W-1:0] = irq_mask_r;
            `DSF_OFS_CONFIG:
                rd_nxt[1:0] = config_r;
            default:
                rd_nxt = {`DSF_DATA_W{1'b0}};
        endcase
    end

    // read data valid only in the cycle after the strobe; device status bit 2 always zero
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_r <= {`DSF_DATA_W{1'b0}};
        else if (reg_rd_stb)
            reg_rdata_r <= rd_nxt;
        else
            reg_rdata_r <= {`DSF_DATA_W{1'b0}};
    end

endmodule // dsf_status_bank
`default_nettype wire

/* File: common/dsf_defs.vh */
// register map, field positions and reset values of the status and fault-summary block
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define DSF_ADDR_W 8
`define DSF_DATA_W 16
`define DSF_OFS_DEVICE_STATUS 8'h51
`define DSF_OFS_FAULT_SUMMARY 8'h52
`define DSF_OFS_IRQ_STATUS 8'h60
`define DSF_OFS_IRQ_MASK 8'h61
`define DSF_OFS_CONFIG 8'h62

// ****************************************
// device_status fields
// ****************************************
`define DSF_ST_FAULT 7
`define DSF_ST_CHAIN_LIVE 6
`define DSF_ST_CHAIN_SEEN 5
`define DSF_ST_LINK_CLEAR 4
`define DSF_ST_LINK_RESET 3
`define DSF_ST_NEW_SAMPLE 1
`define DSF_ST_INIT 0

// ****************************************
// fault_class_summary fields
// ****************************************
`define DSF_NUM_CLASSES 10
`define DSF_SUM_LSB 6

// ****************************************
// config fields and reset values
// ****************************************
`define DSF_CFG_HIGH_EN 0
`define DSF_CFG_SELF_CLEAR 1
`define DSF_CFG_RESET 2'h0
`define DSF_IRQ_W 5
`define DSF_IRQ_MASK_RESET 5'h00

// ****************************************
// interrupt status bits
// ****************************************
`define DSF_IRQ_FAULT 0
`define DSF_IRQ_CHAIN 1
`define DSF_IRQ_LINK_CLEAR 2
`define DSF_IRQ_LINK_RESET 3
`define DSF_IRQ_NEW_SAMPLE 4

`endif

/* File: bench/dsf_monitor.sv */
// assertion checker of the status and fault-summary bank
`timescale 1ns/1ps
`default_nettype none
module dsf_monitor #(parameter NUM_CLASSES = 10) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [NUM_CLASSES-1:0] class_cond,
    input wire logic [15:0] reg_rdata_r,
    input wire logic fault_out_r,
    input wire logic init_continue_r,
    input wire logic [NUM_CLASSES-1:0] class_clear_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // read data of the two registers
    sum_rsvd_a: assert property ($past(reg_rd_stb) && $past(reg_addr) == 8'h52 |-> reg_rdata_r[5:0] == 6'h00)
        else $error("summary low bits set");
    stat_rsvd_a: assert property ($past(reg_rd_stb) && $past(reg_addr) == 8'h51 |-> {reg_rdata_r[15:8], reg_rdata_r[2]} == 9'h000)
        else $error("status reserved bits set");
    sum_track_a: assert property ($past(reg_rd_stb) && $past(reg_addr) == 8'h52
        |-> (reg_rdata_r[15:6] & $past(class_cond) & $past(class_cond, 2)) == ($past(class_cond) & $past(class_cond, 2)))
        else $error("summary misses a class");
    stat_fault_a: assert property ($past(reg_rd_stb) && $past(reg_addr) == 8'h51
        && ($past(class_cond) & $past(class_cond, 2)) != 0 |-> reg_rdata_r[7])
        else $error("fault bit low");
    // class clear pulses, init continue pulse and fault output delay
    clr_pulse_a: assert property ($past(reg_wr_stb) && $past(reg_addr) == 8'h52 |-> class_clear_r == $past(reg_wdata[15:6]))
        else $error("class clear wrong");
    clr_quiet_a: assert property (!($past(reg_wr_stb) && $past(reg_addr) == 8'h52) |-> class_clear_r == 0)
        else $error("class clear unasked");
    init_pulse_a: assert property (init_continue_r |-> $past(reg_wr_stb) && $past(reg_addr) == 8'h51 && $past(reg_wdata[0]))
        else $error("init continue unasked");
    fault_set_a: assert property (class_cond != 0 |-> ##[1:3] fault_out_r)
        else $error("fault output late");
endmodule // dsf_monitor
bind dsf_status_bank dsf_monitor #(.NUM_CLASSES(NUM_CLASSES)) u_mon(.*);
`default_nettype wire

/* File: bench/dsf_far_model.sv */
// far-side event source and init sequencer
`timescale 1ns/1ps
`default_nettype none
module dsf_far_model (
    input wire logic mclk,
    input wire logic init_continue_r,
    output logic chain_fault_in,
    output logic link_clear_evt,
    output logic link_reset_evt,
    output logic sample_done,
    output logic sample_is_auto,
    output logic result_read,
    output logic init_done,
    output logic [9:0] class_cond
);
    // idle levels
    initial
    begin
        {chain_fault_in, link_clear_evt, link_reset_evt, sample_done, sample_is_auto, result_read, init_done} = 7'h00;
        class_cond = 10'h000;
    end
    // one-cycle events: clear, reset, done, auto, read
    task fire(input logic [4:0] sel);
        @(posedge mclk);
        {link_clear_evt, link_reset_evt, sample_done, sample_is_auto, result_read} <= sel;
        @(posedge mclk);
        {link_clear_evt, link_reset_evt, sample_done, sample_is_auto, result_read} <= 5'h00;
    endtask
    // init ends once rail wait is dropped
    always @(posedge mclk)
        if (init_continue_r)
            init_done <= 1'b1;
endmodule // dsf_far_model
`default_nettype wire

/* File: bench/tb.sv */
// self-checking testbench of the status and fault-summary bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr_stb = 1'b0, reg_rd_stb = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_r;
    logic chain_fault_in, link_clear_evt, link_reset_evt, sample_done, sample_is_auto, result_read, init_done;
    logic fault_out_r, irq_r, init_continue_r;
    logic [9:0] class_cond, class_clear_r;
    int errors = 0, compares = 0;
    always #12.5 mclk = ~mclk;
    dsf_far_model u_far(.*);
    dsf_status_bank u_dut(.*);
    // compare and count
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle write
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        {reg_wr_stb, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr_stb <= 1'b0;
    endtask
    // one-cycle read, data checked in the next cycle
    task rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        {reg_rd_stb, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd_stb <= 1'b0;
        #1 chk("rdata", reg_rdata_r, e);
    endtask
    task final_report;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #100000;
        errors++;
        final_report;
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(8'h51, 16'h0001);
        wr(8'h51, 16'h00fe);
        rdc(8'h51, 16'h0001);
        wr(8'h51, 16'h0001);
        repeat (3) @(posedge mclk);
        rdc(8'h51, 16'h0000);
        wr(8'h61, 16'h0004);
        u_far.fire(5'h18);
        rdc(8'h51, 16'h0018);
        chk("irq", irq_r, 16'h0001);
        wr(8'h60, 16'h001f);
        wr(8'h51, 16'h0008);
        rdc(8'h51, 16'h0010);
        chk("irq", irq_r, 16'h0000);
        wr(8'h51, 16'h0010);
        u_far.fire(5'h06);
        rdc(8'h51, 16'h0000);
        u_far.fire(5'h04);
        wr(8'h51, 16'h0002);
        rdc(8'h51, 16'h0002);
        u_far.fire(5'h01);
        rdc(8'h51, 16'h0000);
        wr(8'h62, 16'h0001);
        @(posedge mclk) u_far.chain_fault_in <= 1'b1;
        rdc(8'h51, 16'h0060);
        chk("fault", fault_out_r, 16'h0001);
        @(posedge mclk) u_far.chain_fault_in <= 1'b0;
        rdc(8'h51, 16'h0020);
        chk("fault", fault_out_r, 16'h0000);
        wr(8'h62, 16'h0000);
        rdc(8'h51, 16'h0000);
        @(posedge mclk) u_far.chain_fault_in <= 1'b1;
        rdc(8'h51, 16'h0000);
        chk("fault", fault_out_r, 16'h0000);
        @(posedge mclk) u_far.chain_fault_in <= 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            @(posedge mclk) u_far.class_cond <= 10'h001 << i;
            rdc(8'h52, 16'h0040 << i);
            rdc(8'h51, 16'h0080);
            @(posedge mclk) u_far.class_cond <= 10'h000;
            wr(8'h52, ~(16'h0040 << i));
            rdc(8'h52, 16'h0040 << i);
            wr(8'h52, 16'h0040 << i);
            rdc(8'h52, 16'h0000);
        end
        wr(8'h62, 16'h0002);
        @(posedge mclk) u_far.class_cond <= 10'h3ff;
        rdc(8'h52, 16'hffc0);
        @(posedge mclk) u_far.class_cond <= 10'h000;
        rdc(8'h52, 16'h0000);
        rdc(8'h70, 16'h0000);
        final_report;
    end
endmodule // tb
`default_nettype wire
